// >>> logic/pis_pkg.sv
package pis_pkg;

    // Management register indices on the serial management port.
    localparam logic [4:0]  REG_ACC_CTRL    = 5'h0D;
    localparam logic [4:0]  REG_ACC_DATA    = 5'h0E;
    localparam logic [4:0]  REG_IRQ_FLAGS   = 5'h1D;
    localparam logic [4:0]  REG_IRQ_MASK    = 5'h1E;
    localparam logic [4:0]  REG_LINK_STATUS = 5'h1F;

    // Field positions of the flag, mask and status registers.
    localparam int          FLAG_LSB        = 1;
    localparam int          FLAG_MSB        = 8;
    localparam int          AUTODONE_BIT    = 12;
    localparam int          RSV_MSB         = 11;
    localparam int          RSV_LSB         = 5;
    localparam int          SPEED_MSB       = 4;
    localparam int          SPEED_LSB       = 2;
    localparam logic [6:0]  RSV_RESET       = 7'h02;
    localparam logic [7:0]  MASK_RESET      = 8'h00;

    // Resolved speed and duplex codes.
    localparam logic [2:0]  SPD_10_HALF     = 3'h1;
    localparam logic [2:0]  SPD_10_FULL     = 3'h5;
    localparam logic [2:0]  SPD_100_HALF    = 3'h2;
    localparam logic [2:0]  SPD_100_FULL    = 3'h6;

    // Indirect access control fields and function codes.
    localparam int          ACC_FN_MSB      = 15;
    localparam int          ACC_FN_LSB      = 14;
    localparam int          TARGET_DEVICE_ADDRESS_MSB       = 4;
    localparam int          TARGET_DEVICE_ADDRESS_LSB       = 0;
    localparam logic [1:0]  FN_ADDRESS      = 2'h0;
    localparam logic [1:0]  FN_DATA         = 2'h1;

    // Extended devices and their register indices.
    localparam logic [4:0]  DEV_PCS         = 5'h03;
    localparam logic [4:0]  DEV_VENDOR      = 5'h1E;
    localparam logic [15:0] IDX_PRESENT1    = 16'h0005;
    localparam logic [15:0] IDX_PRESENT2    = 16'h0006;
    localparam logic [15:0] IDX_WAKE_FIRST  = 16'h8010;
    localparam logic [15:0] IDX_WAKE_LAST   = 16'h8012;
    localparam logic [15:0] IDX_BMASK_FIRST = 16'h8021;
    localparam logic [15:0] IDX_BMASK_LAST  = 16'h8028;
    localparam logic [15:0] IDX_RXCFG_FIRST = 16'h8061;
    localparam logic [15:0] IDX_RXCFG_LAST  = 16'h8064;
    localparam logic [15:0] IDX_VID1        = 16'h0002;
    localparam logic [15:0] IDX_VID2        = 16'h0003;
    localparam logic [15:0] IDX_VSTATUS     = 16'h0008;
    localparam logic [15:0] IDX_THR_MATCH   = 16'h000B;
    localparam logic [15:0] IDX_THR_SHORT   = 16'h000C;
    localparam logic [15:0] IDX_PKG1        = 16'h000E;
    localparam logic [15:0] IDX_PKG2        = 16'h000F;
    localparam logic [15:0] PCS_PRESENT1    = 16'h0088;
    localparam logic [15:0] PCS_PRESENT2    = 16'h4000;
    localparam logic [15:0] VEND_RO_VALUE   = 16'h0000;

    // Storage slots of the writable extended registers.
    localparam int          EXT_AW          = 5;
    localparam int          EXT_DEPTH       = 32;
    localparam logic [4:0]  SLOT_WAKE       = 5'h00;
    localparam logic [4:0]  SLOT_BMASK      = 5'h03;
    localparam logic [4:0]  SLOT_RXCFG      = 5'h0B;
    localparam logic [4:0]  SLOT_THR_MATCH  = 5'h0F;
    localparam logic [4:0]  SLOT_THR_SHORT  = 5'h10;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pis_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } pis_resp_t;

    typedef struct packed {
        logic       autoneg_done;
        logic [2:0] speed_duplex;
    } pis_link_t;

    typedef struct packed {
        logic        hit;
        logic        writable;
        logic [4:0]  slot;
        logic [15:0] ro_value;
    } pis_ext_dec_t;

    typedef enum logic [1:0] {
        RD_IDLE   = 2'h0,
        RD_FETCH  = 2'h1,
        RD_ANSWER = 2'h3
    } pis_rd_state_t;

endpackage

// >>> logic/pis_flags.sv
`timescale 1ns/1ps

module pis_flags (
    input  wire logic                                          i_clk,
    input  wire logic                                          i_reset,
    input  wire logic [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB]    i_events,
    input  wire logic                                          i_clear,
    output logic      [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB]    o_flags
);

    typedef struct packed {
        logic [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] flags;
    } pis_flag_state_t;

    pis_flag_state_t s_q;
    pis_flag_state_t s_d;

    // Each flag latches its event; an event in the clearing cycle wins so none is lost.
    always_comb begin
        s_d = s_q;
        for (int k = pis_pkg::FLAG_LSB; k <= pis_pkg::FLAG_MSB; k++) begin
            s_d.flags[k] = (s_q.flags[k] & ~i_clear) | i_events[k];
        end
    end

    // Bit 8 wake, 7 energy, 6 autoneg done, 5 remote fault, 4 link down,
    // 3 partner acknowledge, 2 parallel detect fault, 1 page received.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Flags leave straight from their flip-flops.
    assign o_flags = s_q.flags;

endmodule // pis_flags

// >>> logic/pis_ext_mem.sv
`timescale 1ns/1ps

module pis_ext_mem (
    input  wire logic                         i_clk,
    input  wire logic                         i_reset,
    input  wire logic                         i_we,
    input  wire logic [pis_pkg::EXT_AW-1:0]   i_waddr,
    input  wire logic [15:0]                  i_wdata,
    input  wire logic [pis_pkg::EXT_AW-1:0]   i_raddr,
    output logic      [15:0]                  o_rdata
);

    logic [15:0] mem_q [pis_pkg::EXT_DEPTH];
    logic [15:0] rdata_q;

    // Writable extended registers; cleared at reset so software sees defined values.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int k = 0; k < pis_pkg::EXT_DEPTH; k++) begin
                mem_q[k] <= '0;
            end
        end else if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // Registered read port: data appear one edge after the address.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[i_raddr];
        end
    end

    assign o_rdata = rdata_q;

endmodule // pis_ext_mem

// >>> logic/pis_top.sv
`timescale 1ns/1ps

// Behaviour
// - Flag bit 8 sets when a wake-up event is detected.
// - Flag bit 7 sets when energy on the line is detected.
// - Flag bit 6 sets when auto-negotiation completes.
// - Flag bit 5 sets when the partner signals a remote fault.
// - Flag bit 4 sets when link status drops.
// - Flag bit 3 sets on a partner acknowledge during auto-negotiation.
// - Flag bit 2 sets on a parallel detection fault.
// - Flag bit 1 sets when an auto-negotiation page arrives.
// - Mask bits 8 to 1 pair one-to-one with the same flag bits.
// - Mask zero blocks a source, one enables it; mask resets to zero.
// - Status bit 12 reads one only when auto-negotiation is done.
// - Status bits 11 to 5 reset to 0000010b; host writes that pattern there.
// - Status bits 4 to 2 report resolved speed and duplex code.
// - Extended registers are reached only through control and address/data registers.
// - Extended devices 3 and 30 are supported.
// - In data mode, address/data reads and writes reach the chosen extended register.
// - Device 3 decodes indices 5, 6, 32784-32786, 32801-32808, 32865-32868.
// - Device 30 decodes indices 2, 3, 5, 6, 8, 11, 12, 14, 15.
module pis_top #(
    parameter logic [15:0] VENDOR_ID1 = 16'h0101, // Arbitrary value.
    parameter logic [15:0] VENDOR_ID2 = 16'h0202, // Arbitrary value.
    parameter logic [15:0] PACKAGE_ID1 = 16'h0303, // Arbitrary value.
    parameter logic [15:0] PACKAGE_ID2 = 16'h0404  // Arbitrary value.
) (
    input  wire logic                                        i_clk,
    input  wire logic                                        i_reset,
    input  wire pis_pkg::pis_req_t                           i_req,
    input  wire pis_pkg::pis_link_t                          i_link,
    input  wire logic [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB]  i_events,
    output pis_pkg::pis_resp_t                               o_resp,
    output logic                                             o_irq
);

    typedef struct packed {
        pis_pkg::pis_rd_state_t                     st;
        logic [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] mask;
        logic [pis_pkg::RSV_MSB:pis_pkg::RSV_LSB]   rsv;
        logic [1:0]                                 acc_fn;
        logic [4:0]                                 target_device_address;
        logic [15:0]                                ext_index;
        logic [15:0]                                hold;
        logic                                       from_mem;
        logic [15:0]                                rdata;
        logic                                       rvalid;
        logic                                       irq;
    } pis_top_state_t;

    pis_top_state_t                             s_q;
    pis_top_state_t                             s_d;
    logic [pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] flags;
    logic                                       take_rd;
    logic                                       flag_clear;
    logic                                       mem_we;
    logic [15:0]                                mem_rdata;
    pis_pkg::pis_ext_dec_t                      dec;

    // Maps a device and index to storage slot or fixed value; misses read zero.
    function automatic pis_pkg::pis_ext_dec_t ext_decode(input logic [4:0]  target_device_address,
                                                        input logic [15:0] idx);
        pis_pkg::pis_ext_dec_t r;
        r = '0;
        if (target_device_address == pis_pkg::DEV_PCS) begin
            if (idx == pis_pkg::IDX_PRESENT1) begin
                r.hit      = 1'b1;
                r.ro_value = pis_pkg::PCS_PRESENT1;
            end else if (idx == pis_pkg::IDX_PRESENT2) begin
                r.hit      = 1'b1;
                r.ro_value = pis_pkg::PCS_PRESENT2;
            end else if (idx >= pis_pkg::IDX_WAKE_FIRST && idx <= pis_pkg::IDX_WAKE_LAST) begin
                r.hit      = 1'b1;
                r.writable = 1'b1;
                r.slot     = pis_pkg::SLOT_WAKE + 5'(idx - pis_pkg::IDX_WAKE_FIRST);
            end else if (idx >= pis_pkg::IDX_BMASK_FIRST
                         && idx <= pis_pkg::IDX_BMASK_LAST) begin
                r.hit      = 1'b1;
                r.writable = 1'b1;
                r.slot     = pis_pkg::SLOT_BMASK + 5'(idx - pis_pkg::IDX_BMASK_FIRST);
            end else if (idx >= pis_pkg::IDX_RXCFG_FIRST
                         && idx <= pis_pkg::IDX_RXCFG_LAST) begin
                r.hit      = 1'b1;
                r.writable = 1'b1;
                r.slot     = pis_pkg::SLOT_RXCFG + 5'(idx - pis_pkg::IDX_RXCFG_FIRST);
            end
        end else if (target_device_address == pis_pkg::DEV_VENDOR) begin
            r.hit = 1'b1;
            case (idx)
                pis_pkg::IDX_VID1:      r.ro_value = VENDOR_ID1;
                pis_pkg::IDX_VID2:      r.ro_value = VENDOR_ID2;
                pis_pkg::IDX_PKG1:      r.ro_value = PACKAGE_ID1;
                pis_pkg::IDX_PKG2:      r.ro_value = PACKAGE_ID2;
                pis_pkg::IDX_PRESENT1,
                pis_pkg::IDX_PRESENT2,
                pis_pkg::IDX_VSTATUS:   r.ro_value = pis_pkg::VEND_RO_VALUE;
                pis_pkg::IDX_THR_MATCH: begin
                    r.writable = 1'b1;
                    r.slot     = pis_pkg::SLOT_THR_MATCH;
                end
                pis_pkg::IDX_THR_SHORT: begin
                    r.writable = 1'b1;
                    r.slot     = pis_pkg::SLOT_THR_SHORT;
                end
                default:                r.hit = 1'b0;
            endcase
        end
        return r;
    endfunction

    // Decode of the currently selected extended register, shared by read and write.
    assign dec = ext_decode(s_q.target_device_address, s_q.ext_index);

    // A read is taken unless the previous one is still fetching its data.
    assign take_rd    = i_req.rd && (s_q.st != pis_pkg::RD_FETCH);
    assign flag_clear = take_rd && (i_req.addr == pis_pkg::REG_IRQ_FLAGS);

    // Data-mode writes to address/data land in extended storage; read-only ones are dropped.
    assign mem_we = i_req.wr && (i_req.addr == pis_pkg::REG_ACC_DATA)
                    && (s_q.acc_fn == pis_pkg::FN_DATA) && dec.hit && dec.writable;

    pis_flags u_flags (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_events (i_events),
        .i_clear  (flag_clear),
        .o_flags  (flags)
    );

    pis_ext_mem u_ext_mem (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_we     (mem_we),
        .i_waddr  (dec.slot),
        .i_wdata  (i_req.wdata),
        .i_raddr  (dec.slot),
        .o_rdata  (mem_rdata)
    );

    // Register writes, read capture and the two-edge answer pipeline.
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.irq    = |(flags & s_q.mask);

        if (i_req.wr) begin
            case (i_req.addr)
                pis_pkg::REG_IRQ_MASK: begin
                    s_d.mask = i_req.wdata[pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB];
                end
                pis_pkg::REG_LINK_STATUS: begin
                    s_d.rsv = i_req.wdata[pis_pkg::RSV_MSB:pis_pkg::RSV_LSB];
                end
                pis_pkg::REG_ACC_CTRL: begin
                    s_d.acc_fn = i_req.wdata[pis_pkg::ACC_FN_MSB:pis_pkg::ACC_FN_LSB];
                    s_d.target_device_address  = i_req.wdata[pis_pkg::TARGET_DEVICE_ADDRESS_MSB:pis_pkg::TARGET_DEVICE_ADDRESS_LSB];
                end
                pis_pkg::REG_ACC_DATA: begin
                    // Only the address function moves the index; data writes go to storage.
                    if (s_q.acc_fn == pis_pkg::FN_ADDRESS) begin
                        s_d.ext_index = i_req.wdata;
                    end
                end
                default: begin
                    s_d.acc_fn = s_q.acc_fn;
                end
            endcase
        end

        case (s_q.st)
            pis_pkg::RD_FETCH: begin
                // Extended storage answers one edge late, so the choice is made here.
                s_d.rdata  = s_q.from_mem ? mem_rdata : s_q.hold;
                s_d.rvalid = 1'b1;
                s_d.st     = pis_pkg::RD_ANSWER;
            end
            pis_pkg::RD_IDLE,
            pis_pkg::RD_ANSWER: begin
                s_d.st = pis_pkg::RD_IDLE;
            end
            default: begin
                s_d.st = pis_pkg::RD_IDLE;
            end
        endcase

        // The value is captured before the flags clear so the host sees what it cleared.
        if (take_rd) begin
            s_d.st       = pis_pkg::RD_FETCH;
            s_d.hold     = '0;
            s_d.from_mem = 1'b0;
            case (i_req.addr)
                pis_pkg::REG_IRQ_FLAGS: begin
                    s_d.hold[pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] = flags;
                end
                pis_pkg::REG_IRQ_MASK: begin
                    s_d.hold[pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] = s_q.mask;
                end
                pis_pkg::REG_LINK_STATUS: begin
                    s_d.hold[pis_pkg::AUTODONE_BIT] = i_link.autoneg_done;
                    s_d.hold[pis_pkg::RSV_MSB:pis_pkg::RSV_LSB] = s_q.rsv;
                    s_d.hold[pis_pkg::SPEED_MSB:pis_pkg::SPEED_LSB] =
                        i_link.speed_duplex;
                end
                pis_pkg::REG_ACC_CTRL: begin
                    s_d.hold[pis_pkg::ACC_FN_MSB:pis_pkg::ACC_FN_LSB] = s_q.acc_fn;
                    s_d.hold[pis_pkg::TARGET_DEVICE_ADDRESS_MSB:pis_pkg::TARGET_DEVICE_ADDRESS_LSB]   = s_q.target_device_address;
                end
                pis_pkg::REG_ACC_DATA: begin
                    if (s_q.acc_fn == pis_pkg::FN_DATA) begin
                        s_d.from_mem = dec.hit && dec.writable;
                        s_d.hold     = dec.ro_value;
                    end else begin
                        s_d.hold = s_q.ext_index;
                    end
                end
                default: begin
                    s_d.hold = '0;
                end
            endcase
        end
    end

    // State register; the mask resets to all-blocked and reserved bits to their pattern.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q        <= '0;
            s_q.st     <= pis_pkg::RD_IDLE;
            s_q.mask   <= pis_pkg::MASK_RESET;
            s_q.rsv    <= pis_pkg::RSV_RESET;
            s_q.acc_fn <= pis_pkg::FN_ADDRESS;
        end else begin
            s_q <= s_d;
        end
    end

    // All outputs come straight from flip-flops.
    assign o_resp.valid = s_q.rvalid;
    assign o_resp.data  = s_q.rdata;
    assign o_irq        = s_q.irq;

    // An event is visible in its flag one edge later.
    a_event_sets_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_events != '0) |=> ((flags & $past(i_events)) == $past(i_events)))
        else $error("event did not set its flag");

    // Set flags hold until a flag register read.
    a_flag_sticky_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        !flag_clear |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag dropped without a read");

    // A read with no new event leaves all flags clear.
    a_read_clears_flags: assert property (@(posedge i_clk) disable iff (i_reset)
        (flag_clear && (i_events == '0)) |=> (flags == '0))
        else $error("flag read did not clear flags");

    // Mask writes land bit for bit.
    a_mask_write_maps: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_req.wr && i_req.addr == pis_pkg::REG_IRQ_MASK)
        |=> (s_q.mask == $past(i_req.wdata[pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB])))
        else $error("mask write not stored");

    // An enabled flag raises the interrupt on the next edge.
    a_irq_enabled_src: assert property (@(posedge i_clk) disable iff (i_reset)
        ((flags & s_q.mask) != '0) |=> o_irq)
        else $error("interrupt missing for enabled flag");

    // Masked or absent flags keep the interrupt low.
    a_irq_masked_src: assert property (@(posedge i_clk) disable iff (i_reset)
        ((flags & s_q.mask) == '0) |=> !o_irq)
        else $error("interrupt raised by masked flag");

    // Every taken read is answered exactly two edges later.
    a_read_answer_time: assert property (@(posedge i_clk) disable iff (i_reset)
        take_rd |-> ##2 (o_resp.valid ##1 !o_resp.valid))
        else $error("read answer not on the second edge");

    // Status reads return the done bit and speed code as sampled.
    a_status_read_data: assert property (@(posedge i_clk) disable iff (i_reset)
        (take_rd && i_req.addr == pis_pkg::REG_LINK_STATUS)
        |-> ##2 ((o_resp.data[pis_pkg::AUTODONE_BIT] == $past(i_link.autoneg_done, 2))
             && (o_resp.data[pis_pkg::SPEED_MSB:pis_pkg::SPEED_LSB]
                 == $past(i_link.speed_duplex, 2))))
        else $error("status read data wrong");

    // Flag reads return the flags as they stood when taken.
    a_flag_read_value: assert property (@(posedge i_clk) disable iff (i_reset)
        flag_clear |-> ##2
        (o_resp.data[pis_pkg::FLAG_MSB:pis_pkg::FLAG_LSB] == $past(flags, 2)))
        else $error("flag read data wrong");

    // Mask and reserved bits leave reset holding their reset patterns.
    a_reset_patterns: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(i_reset)
        |-> ((s_q.rsv == pis_pkg::RSV_RESET) && (s_q.mask == pis_pkg::MASK_RESET)))
        else $error("reset pattern wrong");

    // Status writes keep bits 11 to 5 exactly as written.
    a_rsv_write_store: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_req.wr && i_req.addr == pis_pkg::REG_LINK_STATUS)
        |=> (s_q.rsv == $past(i_req.wdata[pis_pkg::RSV_MSB:pis_pkg::RSV_LSB])))
        else $error("reserved bits not stored");

    // Status reads return the stored reserved bits.
    a_rsv_read_back: assert property (@(posedge i_clk) disable iff (i_reset)
        (take_rd && i_req.addr == pis_pkg::REG_LINK_STATUS)
        |-> ##2 (o_resp.data[pis_pkg::RSV_MSB:pis_pkg::RSV_LSB] == $past(s_q.rsv, 2)))
        else $error("reserved bits read wrong");

    // Outside the address function a data write must not move the index.
    a_index_data_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_req.wr && i_req.addr == pis_pkg::REG_ACC_DATA && s_q.acc_fn != pis_pkg::FN_ADDRESS)
        |=> $stable(s_q.ext_index))
        else $error("index moved by a data write");

    // Control writes keep the function code and device address.
    a_ctrl_write_store: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_req.wr && i_req.addr == pis_pkg::REG_ACC_CTRL)
        |=> ((s_q.acc_fn == $past(i_req.wdata[pis_pkg::ACC_FN_MSB:pis_pkg::ACC_FN_LSB]))
             && (s_q.target_device_address == $past(i_req.wdata[pis_pkg::TARGET_DEVICE_ADDRESS_MSB:pis_pkg::TARGET_DEVICE_ADDRESS_LSB]))))
        else $error("control write not stored");

    // Storage is written only for the two supported extended devices.
    a_ext_dev_write: assert property (@(posedge i_clk) disable iff (i_reset)
        mem_we |-> (s_q.target_device_address == pis_pkg::DEV_PCS || s_q.target_device_address == pis_pkg::DEV_VENDOR))
        else $error("storage written for unsupported device");

    // A read on the edge after a taken read is refused, so answers never overlap.
    a_read_spacing: assert property (@(posedge i_clk) disable iff (i_reset)
        take_rd |=> !take_rd)
        else $error("read taken during fetch");

    c_flag_read: cover property (@(posedge i_clk) disable iff (i_reset)
        flag_clear && (flags != '0));
    c_irq_rises: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_irq));
    c_ext_write: cover property (@(posedge i_clk) disable iff (i_reset) mem_we);
    c_ext_read: cover property (@(posedge i_clk) disable iff (i_reset)
        take_rd && i_req.addr == pis_pkg::REG_ACC_DATA && s_q.acc_fn == pis_pkg::FN_DATA);
    c_status_read: cover property (@(posedge i_clk) disable iff (i_reset)
        take_rd && i_req.addr == pis_pkg::REG_LINK_STATUS);

endmodule // pis_top

// >>> tb/pis_host.sv
`timescale 1ns/1ps

// Management host model; it drives one-cycle strobes and never leaves stale values.
module pis_host (
    input  wire logic               i_clk,
    output pis_pkg::pis_req_t       o_req,
    input  wire pis_pkg::pis_resp_t i_resp
);
    initial o_req = '0;
    // Released address and data show the inverse, so a stale sample cannot pass.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // A read waits a bounded number of cycles for the answer pulse.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5A5A};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hA5A5};
        for (n = 0; n < 8 && i_resp.valid !== 1'b1; n++) @(negedge i_clk);
        if (i_resp.valid !== 1'b1) begin
            phy_irq_status_mmd_access_test.errors++;
            phy_irq_status_mmd_access_test.tally_and_finish();
        end
        d = i_resp.data;
    endtask
    // Select an extended register in the order the indirect path demands.
    task automatic ext_sel(input logic [4:0] dev, input logic [15:0] idx);
        wr(pis_pkg::REG_ACC_CTRL, {pis_pkg::FN_ADDRESS, 9'h000, dev});
        wr(pis_pkg::REG_ACC_DATA, idx);
        wr(pis_pkg::REG_ACC_CTRL, {pis_pkg::FN_DATA, 9'h000, dev});
    endtask
endmodule // pis_host

// >>> tb/phy_irq_status_mmd_access_test.sv
`timescale 1ns/1ps

module phy_irq_status_mmd_access_test;
    logic               i_clk;
    logic               i_reset;
    pis_pkg::pis_req_t  req;
    pis_pkg::pis_link_t link;
    logic [8:1]         events;
    pis_pkg::pis_resp_t resp;
    logic               irq;
    int                 errors;
    int                 samples_checked;
    logic [15:0]        v;
    logic [2:0]         codes [4];
    logic [4:0]         dv [8];
    logic [15:0]        ix [8];
    logic [15:0]        ex [8];

    // Free-running 10 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    pis_top #(.VENDOR_ID1(16'h0101), .VENDOR_ID2(16'h0202)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_req(req), .i_link(link),
        .i_events(events), .o_resp(resp), .o_irq(irq));
    pis_host HOST (.i_clk(i_clk), .o_req(req), .i_resp(resp));

    // Compare one value and count it.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Pulse events for one cycle, then let flag and interrupt registers settle.
    task automatic pulse(input logic [8:1] e);
        @(posedge i_clk);
        events <= e;
        @(posedge i_clk);
        events <= 8'h00;
        repeat (2) @(negedge i_clk);
    endtask

    initial begin
        i_reset = 1'b1;
        link = '{autoneg_done: 1'b1, speed_duplex: pis_pkg::SPD_100_FULL};
        events = 8'h00;
        codes = '{pis_pkg::SPD_10_HALF, pis_pkg::SPD_10_FULL, pis_pkg::SPD_100_HALF,
                  pis_pkg::SPD_100_FULL};
        dv = '{5'h03, 5'h03, 5'h1E, 5'h1E, 5'h1E, 5'h03, 5'h03, 5'h1E};
        ix = '{16'h0005, 16'h0006, 16'h0002, 16'h0003, 16'h0008, 16'h8010, 16'h8064,
               16'h000B};
        ex = '{16'h0088, 16'h4000, 16'h0101, 16'h0202, 16'h0000, 16'hA5C3, 16'h3C5A,
               16'h0F0F};
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        HOST.rd(pis_pkg::REG_IRQ_MASK, v);
        check(v, 16'h0000);
        HOST.rd(pis_pkg::REG_LINK_STATUS, v);
        check(v[11:5], 7'h02);
        HOST.wr(pis_pkg::REG_LINK_STATUS, {4'h0, 7'h02, 5'h00});
        // Every speed code, with the done bit toggled between passes.
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            link <= '{autoneg_done: i[0], speed_duplex: codes[i]};
            HOST.rd(pis_pkg::REG_LINK_STATUS, v);
            check(v, {3'h0, i[0], 7'h02, codes[i], 2'h0});
        end
        // Each source latches, reads once, then reads clear.
        for (int k = 1; k <= 8; k++) begin
            pulse(8'h01 << (k - 1));
            HOST.rd(pis_pkg::REG_IRQ_FLAGS, v);
            check(v, 16'h0001 << k);
            HOST.rd(pis_pkg::REG_IRQ_FLAGS, v);
            check(v, 16'h0000);
        end
        // Only the enabled source may raise the interrupt.
        HOST.wr(pis_pkg::REG_IRQ_MASK, 16'h0004);
        pulse(8'h01);
        check({15'h0, irq}, 16'h0000);
        pulse(8'h02);
        check({15'h0, irq}, 16'h0001);
        HOST.rd(pis_pkg::REG_IRQ_FLAGS, v);
        check(v, 16'h0006);
        check({15'h0, irq}, 16'h0000);
        HOST.rd(pis_pkg::REG_IRQ_MASK, v);
        check(v, 16'h0004);
        // Extended registers: fixed values first, then writable storage.
        for (int i = 0; i < 8; i++) begin
            HOST.ext_sel(dv[i], ix[i]);
            if (i > 4) HOST.wr(pis_pkg::REG_ACC_DATA, ex[i]);
            HOST.rd(pis_pkg::REG_ACC_DATA, v);
            check(v, ex[i]);
        end
        // Back in the address function the data register shows the index again.
        HOST.wr(pis_pkg::REG_ACC_CTRL, {pis_pkg::FN_ADDRESS, 9'h000, 5'h1E});
        HOST.rd(pis_pkg::REG_ACC_DATA, v);
        check(v, 16'h000B);
        HOST.rd(pis_pkg::REG_ACC_CTRL, v);
        check(v, {pis_pkg::FN_ADDRESS, 9'h000, 5'h1E});
        tally_and_finish();
    end
endmodule // phy_irq_status_mmd_access_test
